/* srl_pkg.sv */
// constants for the reference capture and multiframe clock alignment block
package srl_pkg;
   localparam logic [11:0] ADDR_CLK_DIV = 12'h10b;
   localparam logic [11:0] ADDR_REF_CTRL = 12'h120;
   localparam logic [11:0] ADDR_IGNORE = 12'h121;
   localparam logic [11:0] ADDR_TS_DELAY = 12'h123;
   localparam logic [11:0] ADDR_SH_MON = 12'h128;
   localparam logic [11:0] ADDR_SYNC_MODE = 12'h1ff;
   localparam logic [11:0] ADDR_CB_FN_LO = 12'h559;
   localparam logic [11:0] ADDR_CB_FN_HI = 12'h55a;
   localparam logic [11:0] ADDR_LANE_PLL = 12'h56e;
   localparam logic [11:0] ADDR_LMFC_OFS = 12'h578;
   localparam logic [11:0] ADDR_CB_COUNT = 12'h58f;
   localparam logic [11:0] ADDR_SUBCLASS = 12'h590;
   // field positions
   localparam int REF_TRANS_BIT = 4;
   localparam int REF_EDGE_BIT = 3;
   localparam int REF_MODE_LSB = 1;
   localparam int SYNC_TS_BIT = 0;
   localparam int CB_COUNT_LSB = 6;
   localparam int SUBCLASS_BIT = 5;
   localparam int CB_FN0_LSB = 0;
   localparam int CB_FN1_LSB = 4;
   localparam int CB_FN2_LSB = 0;
   // reset values
   localparam logic [7:0] RST_SUBCLASS = 8'h20;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // field encodings
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_CONT = 2'h1;
   localparam logic [1:0] MODE_NSHOT = 2'h2;
   localparam logic [2:0] FN_SYSREF = 3'h5;
   localparam logic [4:0] OCTETS_ONE = 5'h01;
   localparam logic [4:0] OCTETS_TWO = 5'h02;
   // setup/hold monitor nibbles
   localparam logic [3:0] MON_BEST = 4'h8;
   localparam logic [3:0] MON_HOLD_BAD = 4'hf;
   // least pulse width, in sample clock periods
   localparam int MIN_PULSE_CYC = 2;
endpackage : srl_pkg

/* srl_ref_capture.sv */
// reference input synchroniser and transition detector
`timescale 1ns/1ps
module srl_ref_capture (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ref_pin,
   input wire logic falling_sel,
   output logic ref_level,
   output logic ref_event
);
   logic meta;
   logic stable;
   logic prev;
   wire logic rose;
   wire logic fell;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta <= 1'b0;
         stable <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= ref_pin;
         stable <= meta;
         prev <= stable;
      end
   end

   assign rose = stable && !prev;
   assign fell = !stable && prev;

   // one-cycle capture event on the chosen transition
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ref_event <= 1'b0;
         ref_level <= 1'b0;
      end else begin
         ref_event <= falling_sel ? fell : rose;
         ref_level <= stable;
      end
   end
endmodule : srl_ref_capture

/* srl_sync_core.sv */
// reference capture, multiframe clock alignment and timestamp marking
//
// Overview of operation
// - one bit picks subclass 0 or 1; reset gives subclass 1.
// - subclass 0 runs freely without any reference input.
// - subclass 1 capture realigns multiframe clock and sample dividers.
// - each multiframe clock edge marks a transmitted multiframe start.
// - five-bit offset delays the multiframe clock in frame steps.
// - step per setting: quarter frame, half frame or one frame by octets.
// - control bit picks rising or falling reference transition.
// - control bit picks rising or falling clock edge for sampling.
// - chip sync mode bit: zero normal (reset), one timestamp.
// - timestamp mode marks the sample instead of resetting clocks.
// - three-bit selector per control bit; value 5 carries the marker.
// - control bits are allocated from bit 2 downward.
// - timestamp delay shifts which sample gets the marker.
// - no timestamp arming while decimation is active.
// - writing reference mode selects input type and arms capture.
// - n-shot mode field clears itself after the acted transition.
// - setup/hold monitor register is readable.
// - continuous mode misaligned capture starts a link resync.
// - n-shot mode ignores a programmed count of first events.
// - monitor holds hold status high nibble, setup low; 8 is best.
`timescale 1ns/1ps
module srl_sync_core (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ref_pin,
   input wire logic [4:0] frame_octets,
   input wire logic [5:0] mf_frames,
   input wire logic decim_active,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic lmfc_pulse,
   output logic div_sync,
   output logic div_tick,
   output logic resync_req,
   output logic [2:0] ctrl_bits
);
   logic [7:0] clk_div;
   logic [7:0] ref_ctrl;
   logic [7:0] ignore_cnt;
   logic [7:0] ts_delay;
   logic [7:0] sh_mon;
   logic [7:0] sync_mode;
   logic [7:0] cb_fn_lo;
   logic [7:0] cb_fn_hi;
   logic [7:0] lane_pll;
   logic [7:0] lmfc_ofs;
   logic [7:0] cb_count;
   logic [7:0] subclass;
   logic [4:0] ign_seen;
   logic aligned_once;
   logic evt_late;
   logic [5:0] mf_cnt;
   logic [2:0] div_cnt;
   logic [7:0] ts_cnt;
   logic ts_pend;
   logic [3:0] pre_cnt;
   logic [3:0] pre_last; // count from before the edge cleared it
   logic hold_chk;
   wire logic ref_level;
   wire logic raw_evt;

   srl_ref_capture u_cap (
      .sys_clk(sys_clk),
      .rst(rst),
      .ref_pin(ref_pin),
      .falling_sel(ref_ctrl[srl_pkg::REF_TRANS_BIT]),
      .ref_level(ref_level),
      .ref_event(raw_evt)
   );

   // write strobes
   wire logic wr_clk_div = reg_wr && reg_addr == srl_pkg::ADDR_CLK_DIV;
   wire logic wr_ref = reg_wr && reg_addr == srl_pkg::ADDR_REF_CTRL;
   wire logic wr_ign = reg_wr && reg_addr == srl_pkg::ADDR_IGNORE;
   wire logic wr_tsd = reg_wr && reg_addr == srl_pkg::ADDR_TS_DELAY;
   wire logic wr_sync = reg_wr && reg_addr == srl_pkg::ADDR_SYNC_MODE;
   wire logic wr_fn_lo = reg_wr && reg_addr == srl_pkg::ADDR_CB_FN_LO;
   wire logic wr_fn_hi = reg_wr && reg_addr == srl_pkg::ADDR_CB_FN_HI;
   wire logic wr_pll = reg_wr && reg_addr == srl_pkg::ADDR_LANE_PLL;
   wire logic wr_ofs = reg_wr && reg_addr == srl_pkg::ADDR_LMFC_OFS;
   wire logic wr_cbc = reg_wr && reg_addr == srl_pkg::ADDR_CB_COUNT;
   wire logic wr_sub = reg_wr && reg_addr == srl_pkg::ADDR_SUBCLASS;

   // decoded fields
   wire logic [1:0] ref_mode = ref_ctrl[srl_pkg::REF_MODE_LSB +: 2];
   wire logic mode_cont = ref_mode == srl_pkg::MODE_CONT;
   wire logic mode_nshot = ref_mode == srl_pkg::MODE_NSHOT;
   wire logic ts_mode = sync_mode[srl_pkg::SYNC_TS_BIT];
   wire logic sc1 = subclass[srl_pkg::SUBCLASS_BIT];
   wire logic [1:0] cs = cb_count[srl_pkg::CB_COUNT_LSB +: 2];
   wire logic [4:0] ofs = lmfc_ofs[4:0];

   // falling clock edge capture seen here one cycle later; the skew
   // between the two choices stays a fixed single cycle
   wire logic cap_evt = ref_ctrl[srl_pkg::REF_EDGE_BIT] ?
      evt_late : raw_evt;

   // n-shot: act only after the programmed number was ignored
   wire logic past_ignore = ign_seen >= {1'b0, ignore_cnt[3:0]};
   wire logic take = cap_evt && (mode_cont ||
      (mode_nshot && past_ignore));

   // offset step scales with octets per frame
   wire logic [4:0] shift = (frame_octets == srl_pkg::OCTETS_ONE) ?
      {2'b00, ofs[4:2]} : (frame_octets == srl_pkg::OCTETS_TWO) ?
      {1'b0, ofs[4:1]} : ofs;
   wire logic [5:0] mf_last = mf_frames - 6'h01;
   wire logic at_phase0 = mf_cnt >= mf_last; // wraps like a realign

   // in continuous mode an aligned reference leaves dividers untouched
   wire logic misaligned = mode_cont && aligned_once && !at_phase0;
   wire logic realign = take && sc1 && !ts_mode &&
      (!aligned_once || !at_phase0);
   wire logic [5:0] next_mf = realign ? 6'h00 :
      (mf_cnt >= mf_last) ? 6'h00 : mf_cnt + 6'h01;
   wire logic [2:0] next_div = (realign || div_cnt >= clk_div[2:0]) ?
      3'h0 : div_cnt + 3'h1;

   // timestamp path
   wire logic ts_go = take && ts_mode && !decim_active;
   wire logic ts_fire = ts_pend && ts_cnt == 8'h00;
   wire logic [2:0] cb_enable = {cs != 2'h0, cs >= 2'h2,
      cs == 2'h3};
   wire logic [2:0] cb_func [3];
   assign cb_func[0] = cb_fn_lo[srl_pkg::CB_FN0_LSB +: 3];
   assign cb_func[1] = cb_fn_lo[srl_pkg::CB_FN1_LSB +: 3];
   assign cb_func[2] = cb_fn_hi[srl_pkg::CB_FN2_LSB +: 3];
   wire logic [2:0] mark_mask;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cb
         assign mark_mask[gi] = cb_enable[gi] &&
            cb_func[gi] == srl_pkg::FN_SYSREF;
      end
   endgenerate

   // monitor: setup counts stable pre-transition cycles before the edge
   wire logic pre_level = ref_ctrl[srl_pkg::REF_TRANS_BIT];
   wire logic [3:0] next_pre = (ref_level != pre_level) ? 4'h0 :
      (pre_cnt >= srl_pkg::MON_BEST) ? pre_cnt : pre_cnt + 4'h1;

   // n-shot clear by hardware loses to a software write of the field,
   // because that write is itself a re-arm
   wire logic [7:0] next_ref = wr_ref ? reg_wdata :
      (take && mode_nshot) ? {ref_ctrl[7:3], srl_pkg::MODE_OFF,
      ref_ctrl[0]} : ref_ctrl;

   // read mux; unmapped addresses read zero
   wire logic [7:0] rd_mux =
      (reg_addr == srl_pkg::ADDR_CLK_DIV) ? clk_div :
      (reg_addr == srl_pkg::ADDR_REF_CTRL) ? ref_ctrl :
      (reg_addr == srl_pkg::ADDR_IGNORE) ? ignore_cnt :
      (reg_addr == srl_pkg::ADDR_TS_DELAY) ? ts_delay :
      (reg_addr == srl_pkg::ADDR_SH_MON) ? sh_mon :
      (reg_addr == srl_pkg::ADDR_SYNC_MODE) ? sync_mode :
      (reg_addr == srl_pkg::ADDR_CB_FN_LO) ? cb_fn_lo :
      (reg_addr == srl_pkg::ADDR_CB_FN_HI) ? cb_fn_hi :
      (reg_addr == srl_pkg::ADDR_LANE_PLL) ? lane_pll :
      (reg_addr == srl_pkg::ADDR_LMFC_OFS) ? lmfc_ofs :
      (reg_addr == srl_pkg::ADDR_CB_COUNT) ? cb_count :
      (reg_addr == srl_pkg::ADDR_SUBCLASS) ? subclass : 8'h00;

   // software registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         clk_div <= srl_pkg::RST_ZERO;
         ignore_cnt <= srl_pkg::RST_ZERO;
         ts_delay <= srl_pkg::RST_ZERO;
         sync_mode <= srl_pkg::RST_ZERO;
         cb_fn_lo <= srl_pkg::RST_ZERO;
         cb_fn_hi <= srl_pkg::RST_ZERO;
         lane_pll <= srl_pkg::RST_ZERO;
         lmfc_ofs <= srl_pkg::RST_ZERO;
         cb_count <= srl_pkg::RST_ZERO;
         subclass <= srl_pkg::RST_SUBCLASS;
      end else begin
         if (wr_clk_div) clk_div <= reg_wdata;
         if (wr_ign) ignore_cnt <= reg_wdata;
         if (wr_tsd) ts_delay <= reg_wdata;
         if (wr_sync) sync_mode <= reg_wdata;
         if (wr_fn_lo) cb_fn_lo <= reg_wdata;
         if (wr_fn_hi) cb_fn_hi <= reg_wdata;
         if (wr_pll) lane_pll <= reg_wdata;
         if (wr_ofs) lmfc_ofs <= reg_wdata;
         if (wr_cbc) cb_count <= reg_wdata;
         if (wr_sub) subclass <= reg_wdata;
      end
   end

   // reference control and capture state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ref_ctrl <= srl_pkg::RST_ZERO;
         ign_seen <= 5'h00;
         aligned_once <= 1'b0;
         evt_late <= 1'b0;
      end else begin
         ref_ctrl <= next_ref;
         evt_late <= raw_evt;
         if (wr_ref) begin
            ign_seen <= 5'h00;
            aligned_once <= 1'b0;
         end else begin
            if (cap_evt && mode_nshot && !past_ignore)
               ign_seen <= ign_seen + 5'h01;
            if (realign) aligned_once <= 1'b1;
         end
      end
   end

   // multiframe and sample divider counters
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mf_cnt <= 6'h00;
         div_cnt <= 3'h0;
      end else begin
         mf_cnt <= next_mf;
         div_cnt <= next_div;
      end
   end

   // timestamp delay counter
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ts_pend <= 1'b0;
         ts_cnt <= 8'h00;
      end else if (ts_go) begin
         ts_pend <= 1'b1;
         ts_cnt <= ts_delay;
      end else if (ts_fire) begin
         ts_pend <= 1'b0;
      end else if (ts_pend) begin
         ts_cnt <= ts_cnt - 8'h01;
      end
   end

   // setup/hold monitor
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pre_cnt <= 4'h0;
         pre_last <= 4'h0;
         hold_chk <= 1'b0;
         sh_mon <= srl_pkg::RST_ZERO;
      end else begin
         pre_cnt <= next_pre;
         pre_last <= pre_cnt;
         hold_chk <= raw_evt;
         if (raw_evt)
            sh_mon <= {srl_pkg::MON_BEST, pre_last};
         else if (hold_chk && ref_level == pre_level)
            sh_mon[7:4] <= srl_pkg::MON_HOLD_BAD;
      end
   end

   // registered outputs
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         lmfc_pulse <= 1'b0;
         div_sync <= 1'b0;
         div_tick <= 1'b0;
         resync_req <= 1'b0;
         ctrl_bits <= 3'h0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
         lmfc_pulse <= mf_cnt == {1'b0, shift};
         div_sync <= realign;
         div_tick <= div_cnt == 3'h0;
         resync_req <= take && sc1 && !ts_mode && misaligned;
         ctrl_bits <= ts_fire ? mark_mask : 3'h0;
      end
   end

   subcl_reset_a: assert property (@(posedge sys_clk)
      $fell(rst) |-> sc1)
      else $error("subclass bit not set after reset");

   sub0_free_a: assert property (@(posedge sys_clk)
      disable iff (rst) !sc1 && !wr_sub |=> !div_sync)
      else $error("divider realigned in subclass 0");

   realign_zero_a: assert property (@(posedge sys_clk)
      disable iff (rst) realign |=> mf_cnt == 6'h00 && div_sync &&
      div_cnt == 3'h0)
      else $error("realign did not reset counters");

   lmfc_place_a: assert property (@(posedge sys_clk)
      disable iff (rst) lmfc_pulse |-> $past(mf_cnt) == $past(shift))
      else $error("multiframe edge off its phase");

   edge_sel_a: assert property (@(posedge sys_clk)
      disable iff (rst) ref_ctrl[srl_pkg::REF_EDGE_BIT] && raw_evt &&
      !wr_ref |=> cap_evt)
      else $error("late capture edge lost");

   ts_noreset_a: assert property (@(posedge sys_clk)
      disable iff (rst) take && ts_mode |=> !div_sync)
      else $error("timestamp mode reset the clocks");

   ts_mark_a: assert property (@(posedge sys_clk)
      disable iff (rst) ts_go && ts_delay == 8'h00 |=>
      ##1 ctrl_bits == $past(mark_mask))
      else $error("marker not placed on delayed sample");

   decim_block_a: assert property (@(posedge sys_clk)
      disable iff (rst) decim_active && !ts_pend |=> !ts_pend)
      else $error("timestamp armed while decimating");

   nshot_clear_a: assert property (@(posedge sys_clk)
      disable iff (rst) take && mode_nshot && !wr_ref |=>
      ref_mode == srl_pkg::MODE_OFF)
      else $error("n-shot mode did not self clear");

   resync_a: assert property (@(posedge sys_clk)
      disable iff (rst) take && sc1 && !ts_mode && misaligned |=>
      resync_req ##1 !resync_req)
      else $error("misaligned reference gave no resync");
endmodule : srl_sync_core

/* srl_ref_source.sv */
// reference pulse source standing in for the system clock chip
`timescale 1ns/1ps
module srl_ref_source #(
   parameter int WIDTH = 4
) (
   input wire logic sys_clk,
   input wire logic fire,
   output logic ref_pin
);
   int left = 0;
   // each pulse is held WIDTH clocks, at least twice the divide ratio
   always @(posedge sys_clk) begin
      if (fire) begin
         left <= WIDTH;
      end else if (left != 0) begin
         left <= left - 1;
      end
   end
   // the pin idles low between pulses; no free-running reference
   assign ref_pin = (left != 0);
endmodule : srl_ref_source

/* testbench.sv */
// self-checking bench for the reference capture and alignment block
`timescale 1ns/1ps
module testbench;
   logic sys_clk;
   logic rst;
   logic fire;
   logic ref_pin;
   logic decim_active;
   logic reg_wr;
   logic reg_rd;
   logic [4:0] frame_octets;
   logic [5:0] mf_frames;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic lmfc_pulse;
   logic div_sync;
   logic div_tick;
   logic resync_req;
   logic [2:0] ctrl_bits;
   logic [2:0] last_mark = 3'h0;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int n_sync = 0;
   int n_rsy = 0;
   int n_mark = 0;
   int n_lmfc = 0;
   int n_tick = 0;
   int t_sync = 0;
   int t_mark = 0;
   int t_fire = 0;
   int d_lmfc = 0;
   bit arm = 0;

   srl_sync_core i_srl_sync_core (.sys_clk(sys_clk), .rst(rst),
      .ref_pin(ref_pin), .frame_octets(frame_octets),
      .mf_frames(mf_frames), .decim_active(decim_active),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .lmfc_pulse(lmfc_pulse), .div_sync(div_sync), .div_tick(div_tick),
      .resync_req(resync_req), .ctrl_bits(ctrl_bits));
   srl_ref_source #(.WIDTH(4)) i_srl_ref_source (.sys_clk(sys_clk),
      .fire(fire), .ref_pin(ref_pin));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // sampled on the falling edge so that every output has settled
   always @(negedge sys_clk) begin
      cyc++;
      // an lmfc pulse in the realign cycle still shows the old phase
      if (lmfc_pulse === 1'b1) begin
         n_lmfc++;
         if (arm) d_lmfc = cyc - t_sync;
         arm = 0;
      end
      if (div_sync === 1'b1) begin
         n_sync++;
         t_sync = cyc;
         arm = 1;
      end
      if (div_tick === 1'b1) n_tick++;
      if (resync_req === 1'b1) n_rsy++;
      if (ctrl_bits !== 3'h0) begin
         n_mark++;
         t_mark = cyc;
         last_mark = ctrl_bits;
      end
   end

   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rdc(input logic [11:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk("reg_rdata", e, reg_rdata);
   endtask : rdc

   task pulse(input int gap);
      @(posedge sys_clk);
      fire <= 1'b1;
      t_fire = cyc;
      @(posedge sys_clk);
      fire <= 1'b0;
      repeat (gap) @(posedge sys_clk);
   endtask : pulse

   task t_reset;
      int n;
      rdc(srl_pkg::ADDR_SUBCLASS, srl_pkg::RST_SUBCLASS);
      rdc(srl_pkg::ADDR_SYNC_MODE, srl_pkg::RST_ZERO);
      rdc(12'h300, 8'h00);
      // divide by two keeps the four-cycle reference pulse wide enough
      wr(srl_pkg::ADDR_CLK_DIV, 8'h01);
      wr(srl_pkg::ADDR_LANE_PLL, 8'h00);
      n = n_tick;
      repeat (40) @(posedge sys_clk);
      chk("divider ticks", 8'h14, 8'(n_tick - n));
   endtask : t_reset

   task t_nshot;
      int s;
      s = n_sync;
      wr(srl_pkg::ADDR_REF_CTRL, 8'h04);
      pulse(40);
      chk("realign count", 8'h01, 8'(n_sync - s));
      rdc(srl_pkg::ADDR_REF_CTRL, 8'h00);
      rdc(srl_pkg::ADDR_SH_MON, 8'h88);
      pulse(40);
      chk("disarmed count", 8'h01, 8'(n_sync - s));
   endtask : t_nshot

   task t_edges;
      int l0;
      int l1;
      int l2;
      wr(srl_pkg::ADDR_REF_CTRL, 8'h04);
      pulse(40);
      l0 = t_sync - t_fire;
      wr(srl_pkg::ADDR_REF_CTRL, 8'h14);
      pulse(40);
      l1 = t_sync - t_fire;
      wr(srl_pkg::ADDR_REF_CTRL, 8'h0c);
      pulse(40);
      l2 = t_sync - t_fire;
      chk("falling transition delay", 8'h04, 8'(l1 - l0));
      chk("falling clock delay", 8'h01, 8'(l2 - l0));
   endtask : t_edges

   task t_ignore;
      int s;
      wr(srl_pkg::ADDR_IGNORE, 8'h02);
      wr(srl_pkg::ADDR_REF_CTRL, 8'h04);
      s = n_sync;
      pulse(40);
      pulse(40);
      chk("ignored events", 8'h00, 8'(n_sync - s));
      pulse(40);
      chk("event after ignores", 8'h01, 8'(n_sync - s));
      wr(srl_pkg::ADDR_IGNORE, 8'h00);
   endtask : t_ignore

   task ofs(input logic [7:0] v, output int d);
      wr(srl_pkg::ADDR_LMFC_OFS, v);
      wr(srl_pkg::ADDR_REF_CTRL, 8'h04);
      pulse(80);
      d = d_lmfc;
   endtask : ofs

   task t_offset;
      int d0;
      int d1;
      int d4;
      frame_octets <= 5'h01;
      ofs(8'h00, d0);
      ofs(8'h01, d1);
      ofs(8'h04, d4);
      chk("lmfc after realign", 8'h01, 8'(d0));
      chk("quarter step", 8'h00, 8'(d1 - d0));
      chk("fourth step moves", 8'h01, 8'(d4 - d0));
      frame_octets <= 5'h04;
      ofs(8'h00, d0);
      ofs(8'h01, d1);
      chk("one frame step", 8'h01, 8'(d1 - d0));
      wr(srl_pkg::ADDR_LMFC_OFS, 8'h00);
   endtask : t_offset

   task t_sub0;
      int s;
      int l;
      wr(srl_pkg::ADDR_SUBCLASS, 8'h00);
      wr(srl_pkg::ADDR_REF_CTRL, 8'h04);
      s = n_sync;
      l = n_lmfc;
      pulse(80);
      chk("subclass 0 realign", 8'h00, 8'(n_sync - s));
      chk("lmfc free run", 8'h01, 8'(n_lmfc > l));
      wr(srl_pkg::ADDR_SUBCLASS, srl_pkg::RST_SUBCLASS);
   endtask : t_sub0

   task t_ts;
      int s;
      int m;
      int l0;
      wr(srl_pkg::ADDR_SYNC_MODE, 8'h01);
      wr(srl_pkg::ADDR_CB_COUNT, 8'h40);
      wr(srl_pkg::ADDR_CB_FN_HI, 8'h05);
      wr(srl_pkg::ADDR_REF_CTRL, 8'h02);
      s = n_sync;
      pulse(40);
      chk("timestamp realign", 8'h00, 8'(n_sync - s));
      chk("marker one bit", 8'h04, {5'h0, last_mark});
      l0 = t_mark - t_fire;
      wr(srl_pkg::ADDR_TS_DELAY, 8'h03);
      pulse(40);
      chk("marker delay", 8'h03, 8'(t_mark - t_fire - l0));
      wr(srl_pkg::ADDR_CB_COUNT, 8'h80);
      wr(srl_pkg::ADDR_CB_FN_HI, 8'h00);
      wr(srl_pkg::ADDR_CB_FN_LO, 8'h50);
      pulse(40);
      chk("marker two bits", 8'h02, {5'h0, last_mark});
      decim_active <= 1'b1;
      m = n_mark;
      pulse(40);
      chk("decimated marks", 8'h00, 8'(n_mark - m));
      decim_active <= 1'b0;
      wr(srl_pkg::ADDR_SYNC_MODE, 8'h00);
      wr(srl_pkg::ADDR_TS_DELAY, 8'h00);
   endtask : t_ts

   task t_cont;
      int s;
      int r;
      s = n_sync;
      r = n_rsy;
      wr(srl_pkg::ADDR_REF_CTRL, 8'h02);
      // a period of 40 clocks is ten multiframes
      pulse(38);
      pulse(39);
      chk("first continuous align", 8'h01, 8'(n_sync - s));
      chk("aligned no resync", 8'h00, 8'(n_rsy - r));
      pulse(40);
      chk("misaligned realign", 8'h02, 8'(n_sync - s));
      chk("misaligned resync", 8'h01, 8'(n_rsy - r));
      wr(srl_pkg::ADDR_REF_CTRL, 8'h00);
   endtask : t_cont

   task test_done;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   initial begin
      rst = 1'b1;
      fire = 1'b0;
      decim_active = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      frame_octets = 5'h04;
      mf_frames = 6'h04;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset;
      t_nshot;
      t_edges;
      t_ignore;
      t_offset;
      t_sub0;
      t_ts;
      t_cont;
      test_done;
   end

   // the whole run needs about 1250 clocks; this cuts off a hang
   initial begin
      #80000;
      err_count++;
      $display("watchdog expired");
      test_done;
   end
endmodule : testbench
